/* stepper_pkg.sv */
/*
 * Shared constants, types and table functions for the stepper indexer and
 * the PWM current chopper.
 * Assumes a single 25 MHz system clock and synchronous control inputs.
 */
package stepper_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing.
  localparam int CLK_FREQ_HZ = 25000000; // System clock rate.
  localparam int CLK_PERIOD_PS = 40000; // System clock period.
  localparam int PWM_FREQ_HZ = 50000; // Chopping frequency.
  localparam int BLANK_TIME_PS = 3750000; // Blanking time, 3.75 us.
  localparam int PWM_PERIOD_CYC = CLK_FREQ_HZ / PWM_FREQ_HZ;
  // A least time, so it rounds up to whole cycles.
  localparam int BLANK_CYC = (BLANK_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int MIX_PCT = 75; // Point in the period where mixed turns slow.
  localparam int MIX_POINT_CYC = PWM_PERIOD_CYC * MIX_PCT / 100;
  localparam int SENSE_GAIN = 5; // Sense amplifier gain.

  ////////////////////////////////////////////////////////////////////////////
  // Indexer.
  localparam logic [6:0] POS_HOME = 7'h10; // 45 degrees.
  localparam logic [6:0] FULL_OFFSET = 7'h10; // Full step sits on 45 deg.
  localparam logic [6:0] PCT_FULL = 7'h64; // 100 percent.
  localparam logic [2:0] RES_FULL = 3'h0;
  localparam logic [2:0] RES_HALF = 3'h1;
  localparam logic [2:0] RES_QUARTER = 3'h2;
  localparam logic [2:0] RES_EIGHTH = 3'h3;
  localparam logic [2:0] RES_SIXTEENTH = 3'h4;

  typedef enum logic [1:0] {DECAY_SLOW, DECAY_MIXED, DECAY_FAST} decay_mode_t;

  // Signed winding percentage in sign-magnitude form.
  typedef struct packed {
    logic neg;
    logic [6:0] mag;
  } winding_pct_t;

  // Quarter-wave cosine magnitude, index 0..32 is 0..90 degrees.
  function automatic logic [6:0] cos_mag(input logic [5:0] idx);
    logic [6:0] m;
    m = 7'h00;
    case (idx)
      6'h00, 6'h01, 6'h02: m = 7'h64;
      6'h03: m = 7'h63;
      6'h04: m = 7'h62;
      6'h05: m = 7'h61;
      6'h06: m = 7'h60;
      6'h07: m = 7'h5E;
      6'h08: m = 7'h5C;
      6'h09: m = 7'h5A;
      6'h0A: m = 7'h58;
      6'h0B: m = 7'h56;
      6'h0C: m = 7'h53;
      6'h0D: m = 7'h50;
      6'h0E: m = 7'h4D;
      6'h0F: m = 7'h4A;
      6'h10: m = 7'h47;
      6'h11: m = 7'h43;
      6'h12: m = 7'h3F;
      6'h13: m = 7'h3C;
      6'h14: m = 7'h38;
      6'h15: m = 7'h33;
      6'h16: m = 7'h2F;
      6'h17: m = 7'h2B;
      6'h18: m = 7'h26;
      6'h19: m = 7'h22;
      6'h1A: m = 7'h1D;
      6'h1B: m = 7'h18;
      6'h1C: m = 7'h14;
      6'h1D: m = 7'h0F;
      6'h1E: m = 7'h0A;
      6'h1F: m = 7'h05;
      default: m = 7'h00;
    endcase
    return m;
  endfunction

  // Winding A percentage at a position; winding B uses position minus 32.
  function automatic winding_pct_t pos_to_pct(input logic [6:0] pos);
    winding_pct_t r;
    logic [5:0] fold;
    fold = pos[5:0];
    r.mag = (fold <= 6'h20) ? cos_mag(fold) : cos_mag(6'h20 - (fold - 6'h20));
    r.neg = (pos > 7'h20) && (pos < 7'h60);
    return r;
  endfunction

endpackage

/* chop_timing_if.sv */
/*
 * Carries the shared PWM period timing from the period timer to the two
 * winding choppers.
 * Assumes every party runs on the system clock.
 */
interface chop_timing_if;
  logic period_start; // One-cycle pulse at the start of each PWM period.
  logic mix_late; // Level, high from the mixed-decay switch point to period end.
  modport source (output period_start, output mix_late);
  modport sink (input period_start, input mix_late);
endinterface

/* pwm_period_timer.sv */
/*
 * Free-running PWM period counter shared by both windings.
 * Assumes the system clock; the period is fixed and never restarts.
 */
module pwm_period_timer
  import stepper_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  chop_timing_if.source timing
);

  typedef struct packed {
    logic [9:0] cnt; // Cycle within the period.
    logic start; // Period start pulse.
    logic late; // Past the mixed-decay switch point.
  } timer_state_t;

  timer_state_t state_ff;
  timer_state_t nxt_state;

  ////////////////////////////////////////////////////////////////////////////
  // Count out the fixed period and flag its start and its late part.
  always_comb begin
    nxt_state = state_ff;
    nxt_state.start = 1'b0;
    if (state_ff.cnt == 10'(PWM_PERIOD_CYC - 1)) begin
      nxt_state.cnt = 10'h000;
      nxt_state.start = 1'b1;
    end else begin
      nxt_state.cnt = state_ff.cnt + 10'h001;
    end
    nxt_state.late = (nxt_state.cnt >= 10'(MIX_POINT_CYC));
  end

  // Register the timer state.
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign timing.period_start = state_ff.start;
  assign timing.mix_late = state_ff.late;

endmodule

/* winding_chopper.sv */
/*
 * Current chopper for one H-bridge winding: drive, blanking, decay choice.
 * Assumes a digitised sense value that reads the current's magnitude in
 * either bridge direction, and a reference already scaled by the indexer.
 */
module winding_chopper
  import stepper_pkg::*;
#(
  parameter int SENSE_W = 10,
  parameter int REF_W = 10,
  parameter logic [SENSE_W-1:0] ZERO_LEVEL = '0 // Sense level taken as zero.
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  chop_timing_if.sink timing,
  input wire logic [SENSE_W-1:0] i_sense,
  input wire logic [REF_W-1:0] i_ref_scaled,
  input wire logic i_neg,
  input wire logic i_decreasing,
  input wire decay_mode_t i_decay,
  output logic [3:0] o_gates // pos_hi, pos_lo, neg_hi, neg_lo.
);

  typedef enum logic [1:0] {PH_OFF, PH_DRIVE, PH_FAST, PH_SLOW} phase_t;

  typedef struct packed {
    phase_t phase;
    logic [6:0] blank; // Remaining blanking cycles.
    logic [3:0] gates;
  } chop_state_t;

  chop_state_t state_ff;
  chop_state_t nxt_state;
  logic trip; // Amplified sense has reached the reference.
  logic near_zero; // Decaying current has run down.
  logic [SENSE_W+2:0] amp; // Sense times the gain.

  assign amp = (SENSE_W + 3)'(i_sense) * (SENSE_W + 3)'(SENSE_GAIN);
  assign trip = amp >= (SENSE_W + 3)'(i_ref_scaled);
  assign near_zero = i_sense <= ZERO_LEVEL;

  ////////////////////////////////////////////////////////////////////////////
  // Phase sequencing within each PWM period.
  always_comb begin
    nxt_state = state_ff;
    if (timing.period_start) begin
      nxt_state.phase = PH_DRIVE;
      nxt_state.blank = 7'(BLANK_CYC);
    end else begin
      unique case (state_ff.phase)
        PH_DRIVE: begin
          if (state_ff.blank != 7'h00) begin
            // The comparator is not looked at, so on-time has a floor.
            nxt_state.blank = state_ff.blank - 7'h01;
          end else if (trip) begin
            // Off until the next period start.
            if (i_decay == DECAY_FAST) begin
              nxt_state.phase = PH_FAST;
            end else if (i_decay == DECAY_SLOW) begin
              nxt_state.phase = PH_SLOW;
            end else if (i_decreasing && !timing.mix_late) begin
              nxt_state.phase = PH_FAST;
            end else begin
              nxt_state.phase = PH_SLOW;
            end
          end
        end
        PH_FAST: begin
          if (near_zero) begin
            nxt_state.phase = PH_OFF;
          end else if (i_decay == DECAY_MIXED && timing.mix_late) begin
            nxt_state.phase = PH_SLOW;
          end
        end
        PH_SLOW, PH_OFF: begin
          nxt_state.phase = state_ff.phase;
        end
      endcase
    end
    // Gates follow the phase, mirrored for negative current.
    unique case (nxt_state.phase)
      PH_DRIVE: nxt_state.gates = i_neg ? 4'h6 : 4'h9;
      PH_FAST: nxt_state.gates = i_neg ? 4'h9 : 4'h6;
      PH_SLOW: nxt_state.gates = 4'h5;
      PH_OFF: nxt_state.gates = 4'h0;
    endcase
  end

  // Register the chopper state; the bridge is off during reset.
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= '{phase: PH_OFF, blank: 7'h00, gates: 4'h0};
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign o_gates = state_ff.gates;

endmodule

/* stepper_indexer_current_chopper.sv */
/*
 * Microstepping indexer and two-winding PWM current chopper for a bipolar
 * stepper bridge. Step, direction and resolution drive a 128-entry
 * position counter; each winding's reference is scaled by its table
 * percentage and handed to a chopper that controls four bridge gates.
 * Assumes all inputs are synchronous to i_clk_sys, the sense and reference
 * levels are digitised elsewhere, and the decay pin's three levels come
 * from two threshold comparators outside this block.
 */
module stepper_indexer_current_chopper
  import stepper_pkg::*;
#(
  parameter int SENSE_W = 10, // Width of the digitised sense levels.
  parameter int REF_W = 10 // Width of the digitised reference levels.
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_step,
  input wire logic i_dir,
  input wire logic i_indexer_reset_n,
  input wire logic [2:0] i_step_resolution_select,
  input wire logic i_decay_pin_high,
  input wire logic i_decay_pin_low,
  input wire logic [SENSE_W-1:0] i_winding_sense_in_a,
  input wire logic [SENSE_W-1:0] i_winding_sense_in_b,
  input wire logic [REF_W-1:0] i_winding_reference_level_a,
  input wire logic [REF_W-1:0] i_winding_reference_level_b,
  output logic [1:0] o_winding_out_pos_hi,
  output logic [1:0] o_winding_out_pos_lo,
  output logic [1:0] o_winding_out_neg_hi,
  output logic [1:0] o_winding_out_neg_lo,
  output logic [6:0] o_position,
  output logic o_at_home
);

  ////////////////////////////////////////////////////////////////////////////
  // State of the indexer.

  // All indexer state in one register.
  typedef struct packed {
    logic step_prev; // Step level one cycle ago, for edge finding.
    logic [6:0] pos; // Electrical position, 128 per cycle.
    logic at_home; // Position equals the home state.
    logic [1:0] decr; // Per winding, commanded magnitude fell at last step.
    logic [1:0] neg; // Per winding, negative current.
    logic [REF_W-1:0] ref_a; // Scaled reference, winding A.
    logic [REF_W-1:0] ref_b; // Scaled reference, winding B.
    decay_mode_t decay; // Decoded decay mode.
  } index_state_t;

  index_state_t state_ff; // Registered indexer state.
  index_state_t nxt_state; // Next indexer state.

  logic step_rise; // Rising edge of the step input.
  logic [6:0] inc; // Position increment for the selected resolution.
  logic [6:0] offset; // Origin of the valid-state grid.
  logic [6:0] rel; // Position relative to the grid origin.
  logic [6:0] rel_floor; // Relative position rounded down to the grid.
  logic [6:0] pos_step; // Position after a step.
  logic [6:0] pos_nxt; // Position after this clock edge, indexer reset applied.
  winding_pct_t pct_a_now; // Winding A at the current position.
  winding_pct_t pct_b_now; // Winding B at the current position.
  winding_pct_t pct_a_nxt; // Winding A at the next position.
  winding_pct_t pct_b_nxt; // Winding B at the next position.
  logic [REF_W+6:0] prod_a; // Reference times percentage, winding A.
  logic [REF_W+6:0] prod_b; // Reference times percentage, winding B.
  logic [3:0] gates_a; // Bridge gates from chopper A.
  logic [3:0] gates_b; // Bridge gates from chopper B.

  ////////////////////////////////////////////////////////////////////////////
  // Resolution decode.

  // Each resolution steps by 128 over four times its microsteps per step,
  // and full step keeps to the 45-degree grid where both windings are 71%.
  always_comb begin
    offset = 7'h00;
    unique case (i_step_resolution_select)
      RES_FULL: begin
        inc = 7'h20;
        offset = FULL_OFFSET;
      end
      RES_HALF: inc = 7'h10;
      RES_QUARTER: inc = 7'h08;
      RES_EIGHTH: inc = 7'h04;
      RES_SIXTEENTH: inc = 7'h02;
      default: inc = 7'h01; // The three top codes all mean 1/32 step.
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next position.

  // Snapping to the grid before stepping means a resolution change never
  // leaves the indexer between valid states of the new setting.
  always_comb begin
    rel = state_ff.pos - offset;
    rel_floor = rel & ~(inc - 7'h01);
    if (i_dir) begin
      // Forward: next grid point above the floor.
      pos_step = rel_floor + inc + offset;
    end else if (rel_floor != rel) begin
      // Reverse from off-grid: the floor is the next valid state.
      pos_step = rel_floor + offset;
    end else begin
      // Reverse from on-grid: one grid step back, wrapping at 128.
      pos_step = rel_floor - inc + offset;
    end
  end

  // Kept apart from the state update, so that the table lookups see the
  // next position without a loop back through the state struct.
  always_comb begin
    pos_nxt = state_ff.pos;
    if (!i_indexer_reset_n) begin
      // Indexer reset wins over a step edge in the same cycle.
      pos_nxt = POS_HOME;
    end else if (step_rise) begin
      pos_nxt = pos_step;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Table lookups.

  // Winding B lags winding A by a quarter cycle, 32 positions.
  always_comb begin
    pct_a_now = pos_to_pct(state_ff.pos);
    pct_b_now = pos_to_pct(state_ff.pos - 7'h20);
    pct_a_nxt = pos_to_pct(pos_nxt);
    pct_b_nxt = pos_to_pct(pos_nxt - 7'h20);
  end

  // The DAC scaling: reference times percentage over 100.
  always_comb begin
    prod_a = (REF_W + 7)'(i_winding_reference_level_a) * (REF_W + 7)'(pct_a_nxt.mag);
    prod_b = (REF_W + 7)'(i_winding_reference_level_b) * (REF_W + 7)'(pct_b_nxt.mag);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Indexer next state.

  assign step_rise = i_step && !state_ff.step_prev;

  // Step handling, indexer reset, decay decode and reference scaling.
  always_comb begin
    nxt_state = state_ff;
    // Undriven step, direction, reset and resolution pins arrive here as
    // low, so an idle board sits reset at home in full step.
    nxt_state.step_prev = i_step;
    nxt_state.pos = pos_nxt;
    if (!i_indexer_reset_n) begin
      nxt_state.decr = 2'b00;
    end
    // Record whether each commanded magnitude is falling.
    if (pos_nxt != state_ff.pos) begin
      nxt_state.decr[0] = pct_a_nxt.mag < pct_a_now.mag;
      nxt_state.decr[1] = pct_b_nxt.mag < pct_b_now.mag;
    end
    nxt_state.neg[0] = pct_a_nxt.neg;
    nxt_state.neg[1] = pct_b_nxt.neg;
    nxt_state.at_home = (nxt_state.pos == POS_HOME);
    // Scale each reference by its winding's percentage.
    nxt_state.ref_a = REF_W'(prod_a / (REF_W + 7)'(PCT_FULL));
    nxt_state.ref_b = REF_W'(prod_b / (REF_W + 7)'(PCT_FULL));
    // Three-level decay pin; a conflicting pair reads as open.
    if (i_decay_pin_high && !i_decay_pin_low) begin
      nxt_state.decay = DECAY_FAST;
    end else if (i_decay_pin_low && !i_decay_pin_high) begin
      nxt_state.decay = DECAY_SLOW;
    end else begin
      nxt_state.decay = DECAY_MIXED;
    end
  end

  // Register the indexer state. Power-up lands on home.
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= '{
        step_prev: 1'b0,
        pos: POS_HOME,
        at_home: 1'b1,
        decr: 2'b00,
        neg: 2'b00,
        ref_a: '0,
        ref_b: '0,
        decay: DECAY_MIXED
      };
    end else begin
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Chopping.

  // One period timer keeps both windings in phase, so their drive edges
  // coincide; this trades supply ripple for simpler timing.
  chop_timing_if timing ();

  pwm_period_timer u_timer (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .timing(timing)
  );

  // Winding A chopper.
  winding_chopper #(
    .SENSE_W(SENSE_W),
    .REF_W(REF_W)
  ) u_chop_a (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .timing(timing),
    .i_sense(i_winding_sense_in_a),
    .i_ref_scaled(state_ff.ref_a),
    .i_neg(state_ff.neg[0]),
    .i_decreasing(state_ff.decr[0]),
    .i_decay(state_ff.decay),
    .o_gates(gates_a)
  );

  // Winding B chopper.
  winding_chopper #(
    .SENSE_W(SENSE_W),
    .REF_W(REF_W)
  ) u_chop_b (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .timing(timing),
    .i_sense(i_winding_sense_in_b),
    .i_ref_scaled(state_ff.ref_b),
    .i_neg(state_ff.neg[1]),
    .i_decreasing(state_ff.decr[1]),
    .i_decay(state_ff.decay),
    .o_gates(gates_b)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, each straight from a chopper or indexer flip-flop.

  assign o_winding_out_pos_hi = {gates_b[3], gates_a[3]};
  assign o_winding_out_pos_lo = {gates_b[2], gates_a[2]};
  assign o_winding_out_neg_hi = {gates_b[1], gates_a[1]};
  assign o_winding_out_neg_lo = {gates_b[0], gates_a[0]};
  assign o_position = state_ff.pos;
  assign o_at_home = state_ff.at_home;

endmodule

/* stepper_indexer_current_chopper_assertions.sv */
/* Port checker for the indexer and the winding A chopper.
   Assumes one clock and the asynchronous active-low reset of the top. */
module stepper_chk
  import stepper_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_step,
  input wire logic i_dir,
  input wire logic i_indexer_reset_n,
  input wire logic [2:0] i_step_resolution_select,
  input wire logic i_decay_pin_high,
  input wire logic i_decay_pin_low,
  input wire logic [1:0] o_winding_out_pos_hi,
  input wire logic [1:0] o_winding_out_pos_lo,
  input wire logic [1:0] o_winding_out_neg_hi,
  input wire logic [1:0] o_winding_out_neg_lo,
  input wire logic [6:0] o_position,
  input wire logic o_at_home
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  ////////////////////////////////////////////////////////////////////////////
  logic [3:0] gate_a; // Winding A: pos_hi, pos_lo, neg_hi, neg_lo.
  logic hi_a; // Some high side of winding A is on.
  logic [3:0] drv_a; // Drive pattern of winding A for the current position.
  logic [9:0] on_cnt_ff; // Cycles the high side has stayed on.
  logic [8:0] ph_ff; // Phase since the last high-side turn-on.
  logic seen_ff; // A first turn-on has been seen.
  assign gate_a = {o_winding_out_pos_hi[0], o_winding_out_pos_lo[0],
                   o_winding_out_neg_hi[0], o_winding_out_neg_lo[0]};
  assign hi_a = gate_a[3] | gate_a[1];
  assign drv_a = (o_position > 7'h20 && o_position < 7'h60) ? 4'h6 : 4'h9;
  // Phase counter wraps each period, so several untripped periods stay aligned.
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      on_cnt_ff <= '0;
      ph_ff <= '0;
      seen_ff <= 1'b0;
    end else begin
      on_cnt_ff <= !hi_a ? 10'h000 : on_cnt_ff + {9'h000, ~&on_cnt_ff};
      seen_ff <= seen_ff | $rose(hi_a);
      ph_ff <= $rose(hi_a) ? 9'h001 : (ph_ff == 9'(PWM_PERIOD_CYC - 1)) ? 9'h000 : ph_ff + 9'h001;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  home_flag_a: assert property (o_at_home == (o_position == POS_HOME))
    else $error("home flag disagrees with position");
  ireset_home_a: assert property (!i_indexer_reset_n |=> o_position == POS_HOME)
    else $error("indexer reset did not force home");
  fwd_fine_a: assert property ($rose(i_step) && i_dir && i_indexer_reset_n &&
    i_step_resolution_select >= 3'h5 |=> o_position == $past(o_position) + 7'h01)
    else $error("fine forward step not plus one");
  rev_fine_a: assert property ($rose(i_step) && !i_dir && i_indexer_reset_n &&
    i_step_resolution_select >= 3'h5 |=> o_position == $past(o_position) - 7'h01)
    else $error("fine reverse step not minus one");
  full_grid_a: assert property ($rose(i_step) && i_indexer_reset_n &&
    i_step_resolution_select == 3'h0 |=> o_position[4:0] == 5'h10)
    else $error("full step left the 45 degree grid");
  blank_min_a: assert property ($rose(gate_a == 4'h5) |-> on_cnt_ff >= 10'h05F)
    else $error("drive ended inside blanking");
  period_a: assert property ($rose(hi_a) && seen_ff |-> ph_ff == 9'h000)
    else $error("drive start off the PWM period");
  slow_decay_a: assert property (i_decay_pin_low && !i_decay_pin_high &&
    $fell(hi_a) |-> gate_a == 4'h5)
    else $error("slow decay not both low sides");
  fast_rev_a: assert property ($past(i_decay_pin_high && !i_decay_pin_low) &&
    $past(gate_a) == $past(drv_a) && gate_a != $past(gate_a) |->
    gate_a == ($past(drv_a) ^ 4'hF))
    else $error("fast decay not reversed bridge");
  polarity_a: assert property ($rose(hi_a) && $past(o_position, 3) == o_position |->
    gate_a[1] == (o_position > 7'h20 && o_position < 7'h60))
    else $error("drive polarity wrong for position");
endmodule

bind stepper_indexer_current_chopper stepper_chk u_chk (.i_clk_sys(i_clk_sys),
  .i_rst_n(i_rst_n), .i_step(i_step), .i_dir(i_dir), .i_indexer_reset_n(i_indexer_reset_n),
  .i_step_resolution_select(i_step_resolution_select), .i_decay_pin_high(i_decay_pin_high),
  .i_decay_pin_low(i_decay_pin_low), .o_winding_out_pos_hi(o_winding_out_pos_hi),
  .o_winding_out_pos_lo(o_winding_out_pos_lo), .o_winding_out_neg_hi(o_winding_out_neg_hi),
  .o_winding_out_neg_lo(o_winding_out_neg_lo), .o_position(o_position), .o_at_home(o_at_home));

/* step_dir_source.sv */
/* Motion controller model: one step pulse with its direction per request.
   Assumes requests change at the falling edge; hold sets pulse width, 1 to 7. */
module step_dir_source (
  input wire logic i_clk_sys,
  input wire logic i_go,
  input wire logic i_dir_req,
  input wire logic [2:0] i_hold,
  output logic o_step,
  output logic o_dir,
  output logic o_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle step is low, as a pulled-down input would read.
  initial begin
    o_step = 1'b0;
    o_dir = 1'b0;
    o_busy = 1'b0;
    forever begin
      @(negedge i_clk_sys);
      if (i_go) begin
        o_busy = 1'b1;
        o_dir = i_dir_req; // Set a cycle early and held past the rise.
        @(negedge i_clk_sys);
        o_step = 1'b1; // Exactly one rising edge per request.
        repeat (i_hold) @(negedge i_clk_sys);
        o_step = 1'b0;
        repeat (i_hold) @(negedge i_clk_sys);
        o_busy = 1'b0;
      end
    end
  end
endmodule

/* stepper_indexer_current_chopper_tb.sv */
/* Self-checking bench: random stepping, indexer reset and every decay mode.
   Assumes the controller model drives step and direction. */
module stepper_indexer_current_chopper_tb
  import stepper_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk_sys = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_indexer_reset_n = 1'b1;
  logic [2:0] res = 3'h5;
  logic pin_hi = 1'b0;
  logic pin_lo = 1'b1;
  logic [9:0] sense = 10'h3FF; // Same sense on both windings.
  logic [9:0] ref_a = 10'h200;
  logic [9:0] ref_b = 10'h200;
  logic go = 1'b0;
  logic dir_req = 1'b0;
  logic [2:0] hold = 3'h1;
  logic step, dir, busy, at_home;
  logic [1:0] pos_hi, pos_lo, neg_hi, neg_lo;
  logic [6:0] position;
  logic [3:0] gate_a;
  logic [31:0] lfsr = 32'h4077A0A1;
  logic [6:0] exp_pos = POS_HOME;
  int miscompares = 0;
  int total_checks = 0;
  assign gate_a = {pos_hi[0], pos_lo[0], neg_hi[0], neg_lo[0]};
  always #20 i_clk_sys = ~i_clk_sys;
  ////////////////////////////////////////////////////////////////////////////
  stepper_indexer_current_chopper dut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_step(step), .i_dir(dir), .i_indexer_reset_n(i_indexer_reset_n),
    .i_step_resolution_select(res), .i_decay_pin_high(pin_hi), .i_decay_pin_low(pin_lo),
    .i_winding_sense_in_a(sense), .i_winding_sense_in_b(sense),
    .i_winding_reference_level_a(ref_a), .i_winding_reference_level_b(ref_b),
    .o_winding_out_pos_hi(pos_hi), .o_winding_out_pos_lo(pos_lo),
    .o_winding_out_neg_hi(neg_hi), .o_winding_out_neg_lo(neg_lo),
    .o_position(position), .o_at_home(at_home));
  step_dir_source u_src (.i_clk_sys(i_clk_sys), .i_go(go), .i_dir_req(dir_req),
    .i_hold(hold), .o_step(step), .o_dir(dir), .o_busy(busy));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], 1'b0} ^ (v[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction
  // Snap to the resolution grid, then move; full step sits 16 off zero.
  function automatic logic [6:0] next_pos(input logic [6:0] p, input logic [2:0] r,
                                          input logic d);
    logic [6:0] inc;
    logic [6:0] off;
    logic [6:0] g;
    inc = 7'h20 >> ((r > 3'h5) ? 3'h5 : r);
    off = (r == 3'h0) ? 7'h10 : 7'h00;
    g = ((p - off) & ~(inc - 7'h01)) + off;
    if (d) return g + inc;
    return (p != g) ? g : g - inc;
  endfunction
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic timed_out;
    miscompares++;
    $display("BAD wait expected done seen timeout");
    summarize();
  endtask
  // Ask the controller for one step and wait, bounded, until it is idle.
  task automatic step_once(input logic d, input logic [2:0] h);
    @(negedge i_clk_sys);
    dir_req <= d;
    hold <= h;
    go <= 1'b1;
    @(negedge i_clk_sys);
    go <= 1'b0;
    @(posedge i_clk_sys); // Busy rose at the falling edge just before; it is already high here.
    for (int n = 0; busy; n++) begin
      if (n == 40) timed_out();
      @(posedge i_clk_sys);
    end
    @(negedge i_clk_sys);
  endtask
  // Returns in the first cycle that shows the given drive pattern anew.
  task automatic wait_drive(input logic [3:0] drv);
    logic [3:0] was;
    was = drv;
    for (int n = 0; !(gate_a == drv && was != drv); n++) begin
      if (n == 1100) timed_out();
      was = gate_a;
      @(negedge i_clk_sys);
    end
  endtask
  // One measured period; 4'hF skips a check whose outcome history decides.
  task automatic decay_case(input logic hi, input logic lo, input logic [3:0] drv,
    input logic [9:0] s1, input logic [3:0] mid, input logic [9:0] s2, input logic [3:0] late);
    pin_hi <= hi;
    pin_lo <= lo;
    sense <= 10'h3FF; // Settling periods must trip to end their drive.
    wait_drive(drv);
    wait_drive(drv);
    sense <= s1;
    repeat (49) @(negedge i_clk_sys);
    chk("gates blanked", gate_a, drv);
    chk("gates b", {pos_hi[1], pos_lo[1], neg_hi[1], neg_lo[1]}, 4'h9);
    repeat (150) @(negedge i_clk_sys);
    if (mid != 4'hF) chk("gates mid", gate_a, mid);
    sense <= s2;
    repeat (250) @(negedge i_clk_sys);
    chk("gates late", gate_a, late);
    $display("decay case %b%b done", hi, lo);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(negedge i_clk_sys);
    chk("reset position", position, POS_HOME);
    chk("reset gates", {pos_hi, pos_lo, neg_hi, neg_lo}, 8'h00);
    i_rst_n <= 1'b1;
    $display("reset test done");
    for (int i = 0; i < 80; i++) begin
      lfsr = lfsr_next(lfsr);
      res <= lfsr[2:0];
      step_once(lfsr[3], 3'h1 + {1'b0, lfsr[5:4]});
      exp_pos = next_pos(exp_pos, lfsr[2:0], lfsr[3]);
      chk("position", position, exp_pos);
      chk("home flag", at_home, exp_pos == POS_HOME);
    end
    $display("random step test done");
    i_indexer_reset_n <= 1'b0;
    step_once(1'b1, 3'h2);
    chk("held home", position, POS_HOME);
    i_indexer_reset_n <= 1'b1;
    $display("indexer reset test done");
    ref_a <= lfsr[9:0] | 10'h100;
    ref_b <= lfsr[19:10] | 10'h100;
    decay_case(1'b0, 1'b1, 4'h9, 10'h3FF, 4'h5, 10'h3FF, 4'h5);
    decay_case(1'b1, 1'b0, 4'h9, 10'h3FF, 4'h6, 10'h3FF, 4'h6);
    decay_case(1'b0, 1'b0, 4'h9, 10'h3FF, 4'hF, 10'h3FF, 4'h5);
    decay_case(1'b1, 1'b1, 4'h9, 10'h3FF, 4'hF, 10'h3FF, 4'h5);
    res <= 3'h0;
    step_once(1'b1, 3'h1);
    chk("full step", position, 7'h30);
    decay_case(1'b0, 1'b1, 4'h6, 10'h3FF, 4'h5, 10'h3FF, 4'h5);
    decay_case(1'b1, 1'b0, 4'h6, 10'h3FF, 4'h9, 10'h000, 4'h0);
    decay_case(1'b1, 1'b0, 4'h6, 10'h000, 4'h6, 10'h000, 4'h6);
    ref_a <= 10'h3E8;
    decay_case(1'b0, 1'b1, 4'h6, 10'h08D, 4'h6, 10'h08E, 4'h5);
    summarize();
  end
endmodule
